// File: design/persistent_reservation_manager.sv
`timescale 1ns/1ps
`include "persistent_reservation_defs.svh"
module persistent_reservation_manager
  import persistent_reservation_pkg::*;
#(
  parameter int NUM_KEYS = 4,
  parameter int INIT_W = 3
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic abort_valid_out,
  output logic [INIT_W-1:0] abort_initiator_out,
  output logic [(2**INIT_W)-1:0] ua_pending_out
);
  localparam int IDX_W = $clog2(NUM_KEYS);
  localparam int NUM_INIT = 2**INIT_W;

  // ****************************************************
  // Helper functions
  // ****************************************************
  // Byte-lane merge for software writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // Most significant byte first within a word
  function automatic logic [7:0] byte_of32(input logic [31:0] w, input logic [1:0] i);
    return w[8*(3-int'(i)) +: 8];
  endfunction : byte_of32

  // Search the key table; returns hit flag and slot
  function automatic logic [IDX_W:0] find_key(input logic [NUM_KEYS-1:0][63:0] tab,
                                              input logic [NUM_KEYS-1:0] vld, input key_t k);
    logic [IDX_W:0] r;
    r = '0;
    for (int i = NUM_KEYS-1; i >= 0; i--) begin
      if (vld[i] && tab[i] == k) begin
        r = {1'b1, IDX_W'(i)};
      end
    end
    return r;
  endfunction : find_key

  // Existing reservation against a new one: types 1h/3h block all, 5h/6h block 1h/3h
  function automatic logic type_conflict(input logic [3:0] have, input logic [3:0] want);
    logic have_excl;
    logic want_excl;
    have_excl = (have == TY_WRITE_EXCL) || (have == TY_EXCL_ACCESS);
    want_excl = (want == TY_WRITE_EXCL) || (want == TY_EXCL_ACCESS);
    return have_excl || want_excl;
  endfunction : type_conflict

  // ****************************************************
  // State
  // ****************************************************
  logic ack_reg; // Wishbone acknowledge
  logic [31:0] cmd_reg; // Opcode, action, scope/type, initiator
  logic [15:0] plen_reg; // Parameter list length
  logic [63:0] rkey_reg; // Reservation key
  logic [63:0] skey_reg; // Service-action key
  logic [7:0] rd_ptr_reg; // Byte pointer into read data
  logic [7:0] status_reg; // Completion status
  logic [3:0] sense_reg; // Sense key
  logic [7:0] asc_reg; // Additional sense code
  logic [7:0] ascq_reg; // Additional sense qualifier
  logic [31:0] gen_reg; // Generation counter
  logic unit_res_reg; // Conventional unit reservation active
  logic [NUM_KEYS-1:0] valid_reg; // Slot holds a key
  logic [NUM_KEYS-1:0][63:0] key_tab_reg; // Registered keys
  logic [NUM_KEYS-1:0][INIT_W-1:0] owner_reg; // Owning initiator per slot
  logic [NUM_KEYS-1:0] resv_reg; // Slot holds the reservation
  logic [NUM_KEYS-1:0][3:0] scope_reg; // Reservation scope per slot
  logic [NUM_KEYS-1:0][3:0] type_reg; // Reservation type per slot

  // ****************************************************
  // Bus decode
  // ****************************************************
  logic [7:0] adr; // Word-aligned byte address
  logic wb_fire; // Edge at which an access completes
  logic exec_fire; // Command execution strobe
  assign adr = {wb_adr_in[7:2], 2'b00};
  assign wb_fire = wb_cyc_in && wb_stb_in && ack_reg;
  assign exec_fire = wb_fire && wb_we_in && (adr == `REG_GO);
  assign wb_ack_out = ack_reg;

  // Acknowledge one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_in && wb_stb_in && !ack_reg;
    end
  end

  // Command fields; held by software between commands
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cmd_reg <= 32'h00000000;
      plen_reg <= 16'h0000;
      rkey_reg <= 64'h0000000000000000;
      skey_reg <= 64'h0000000000000000;
    end else if (wb_fire && wb_we_in) begin
      case (adr)
        `REG_CMD: cmd_reg <= merge(cmd_reg, wb_dat_in, wb_sel_in);
        `REG_PLEN: plen_reg <= 16'(merge({16'h0000, plen_reg}, wb_dat_in, wb_sel_in));
        `REG_RKEY_LO: rkey_reg[31:0] <= merge(rkey_reg[31:0], wb_dat_in, wb_sel_in);
        `REG_RKEY_HI: rkey_reg[63:32] <= merge(rkey_reg[63:32], wb_dat_in, wb_sel_in);
        `REG_SKEY_LO: skey_reg[31:0] <= merge(skey_reg[31:0], wb_dat_in, wb_sel_in);
        `REG_SKEY_HI: skey_reg[63:32] <= merge(skey_reg[63:32], wb_dat_in, wb_sel_in);
        default: begin
          // Other offsets hold no command field
        end
      endcase
    end
  end

  // ****************************************************
  // Command decode and table search
  // ****************************************************
  logic [7:0] opcode; // CDB byte 0
  svc_act_t sa; // Service action
  logic [3:0] scope; // Upper nibble of CDB byte 2
  logic [3:0] rtype; // Lower nibble of CDB byte 2
  logic [INIT_W-1:0] init_id; // Requesting initiator
  assign opcode = cmd_reg[`CMD_OPC_LSB +: 8];
  assign sa = svc_act_t'(cmd_reg[`CMD_SA_LSB +: 5]);
  assign scope = cmd_reg[`CMD_SCOPE_LSB +: 4];
  assign rtype = cmd_reg[`CMD_TYPE_LSB +: 4];
  assign init_id = cmd_reg[`CMD_INIT_LSB +: INIT_W];

  logic [IDX_W:0] rk_find; // Reservation key lookup
  logic [IDX_W:0] sk_find; // Service-action key lookup
  assign rk_find = find_key(key_tab_reg, valid_reg, rkey_reg);
  assign sk_find = find_key(key_tab_reg, valid_reg, skey_reg);

  logic own_hit; // Requester owns some slot
  logic [IDX_W-1:0] own_idx; // First slot owned by requester
  logic free_hit; // An empty slot exists
  logic [IDX_W-1:0] free_idx; // First empty slot
  logic res_conflict; // New reservation clashes with a held one
  logic [2:0] nres; // Number of held reservations
  // Scan for requester slot, free slot and clashing reservations
  always_comb begin
    own_hit = 1'b0;
    own_idx = '0;
    free_hit = 1'b0;
    free_idx = '0;
    res_conflict = 1'b0;
    nres = 3'h0;
    for (int i = NUM_KEYS-1; i >= 0; i--) begin
      if (valid_reg[i] && owner_reg[i] == init_id) begin
        own_hit = 1'b1;
        own_idx = IDX_W'(i);
      end
      if (!valid_reg[i]) begin
        free_hit = 1'b1;
        free_idx = IDX_W'(i);
      end
      // A preempted slot no longer counts against the new reservation
      if (resv_reg[i] && !(sa == SA_PREEMPT_ABORT && sk_find[IDX_W] && sk_find[IDX_W-1:0] == IDX_W'(i))) begin
        res_conflict = res_conflict | type_conflict(type_reg[i], rtype);
      end
      nres = nres + {2'b00, resv_reg[i]};
    end
  end

  logic is_reg; // Register-style action
  logic sa_ok; // Action supported
  logic type_ok; // Type supported
  logic foreign_rk; // Reservation key belongs to someone else
  logic [IDX_W-1:0] tgt_idx; // Slot that takes a new reservation
  assign is_reg = (sa == SA_REGISTER) || (sa == SA_REGISTER_IGNORE);
  assign sa_ok = is_reg || (sa == SA_RESERVE) || (sa == SA_RELEASE) || (sa == SA_PREEMPT_ABORT);
  assign type_ok = (rtype == TY_WRITE_EXCL) || (rtype == TY_EXCL_ACCESS) ||
                   (rtype == TY_WRITE_EXCL_REG) || (rtype == TY_EXCL_ACCESS_REG);
  assign foreign_rk = rk_find[IDX_W] && owner_reg[rk_find[IDX_W-1:0]] != init_id;
  assign tgt_idx = rk_find[IDX_W] ? rk_find[IDX_W-1:0] : own_idx;

  logic [7:0] dec_status; // Outcome status
  logic [3:0] dec_sense; // Outcome sense key
  logic [7:0] dec_asc; // Outcome sense code
  logic [7:0] dec_ascq; // Outcome sense qualifier
  logic dec_gen_inc; // Bump generation
  logic dec_wr; // Write key and owner into a slot
  logic [IDX_W-1:0] dec_wr_idx; // Slot written
  logic dec_res_set; // Place reservation
  logic dec_res_clr; // Remove reservation
  logic [IDX_W-1:0] dec_res_idx; // Slot of reservation change
  logic dec_kill; // Drop a preempted slot
  logic dec_unit_set; // Take conventional reservation
  logic dec_unit_clr; // Drop conventional reservation
  logic dec_ptr_rst; // Rewind read data pointer

  // Outcome of the command held in the command registers
  always_comb begin
    dec_status = `ST_GOOD;
    dec_sense = `SK_NONE;
    dec_asc = 8'h00;
    dec_ascq = 8'h00;
    dec_gen_inc = 1'b0;
    dec_wr = 1'b0;
    dec_wr_idx = '0;
    dec_res_set = 1'b0;
    dec_res_clr = 1'b0;
    dec_res_idx = tgt_idx;
    dec_kill = 1'b0;
    dec_unit_set = 1'b0;
    dec_unit_clr = 1'b0;
    dec_ptr_rst = 1'b0;
    case (opcode)
      `OP_PR_OUT: begin
        if (unit_res_reg) begin
          dec_status = `ST_CONFLICT;
        end else if (plen_reg != `PLIST_LEN) begin
          dec_status = `ST_CHECK;
          dec_sense = `SK_ILLEGAL;
          dec_asc = `ASC_PLIST_LEN;
        end else if (!sa_ok || (!is_reg && (scope != `SCOPE_WHOLE_UNIT || !type_ok))) begin
          dec_status = `ST_CHECK;
          dec_sense = `SK_ILLEGAL;
          dec_asc = `ASC_BAD_CDB;
        end else if (is_reg) begin
          // Scope and type are ignored here
          if (sa == SA_REGISTER && rk_find[IDX_W]) begin
            if (foreign_rk) begin
              dec_status = `ST_CONFLICT;
            end else begin
              dec_wr = 1'b1;
              dec_wr_idx = rk_find[IDX_W-1:0];
            end
          end else if (sa == SA_REGISTER_IGNORE && own_hit) begin
            dec_wr = 1'b1;
            dec_wr_idx = own_idx;
          end else if (free_hit) begin
            dec_wr = 1'b1;
            dec_wr_idx = free_idx;
          end else begin
            dec_status = `ST_CONFLICT;
          end
          dec_gen_inc = dec_wr;
        end else if (!own_hit || foreign_rk) begin
          dec_status = `ST_CONFLICT;
        end else if (sa == SA_RELEASE) begin
          // Unknown key or no reservation completes with good status
          if (rk_find[IDX_W] && resv_reg[tgt_idx]) begin
            if (scope_reg[tgt_idx] != scope || type_reg[tgt_idx] != rtype) begin
              dec_status = `ST_CHECK;
              dec_sense = `SK_ILLEGAL;
              dec_asc = `ASC_BAD_RELEASE;
              dec_ascq = `ASCQ_BAD_RELEASE;
            end else begin
              dec_res_clr = 1'b1;
            end
          end
        end else if (res_conflict) begin
          dec_status = `ST_CONFLICT;
        end else begin
          dec_res_set = 1'b1;
          if (sa == SA_PREEMPT_ABORT) begin
            dec_gen_inc = 1'b1;
            dec_kill = sk_find[IDX_W] && sk_find[IDX_W-1:0] != tgt_idx;
          end
        end
      end
      `OP_PR_IN: begin
        if (unit_res_reg) begin
          dec_status = `ST_CONFLICT;
        end else if (cmd_reg[`CMD_SA_LSB +: 5] != `SA_IN_READ_RES) begin
          dec_status = `ST_CHECK;
          dec_sense = `SK_ILLEGAL;
          dec_asc = `ASC_BAD_CDB;
        end else begin
          dec_ptr_rst = 1'b1;
        end
      end
      `OP_RESERVE6, `OP_RESERVE10: begin
        dec_status = (|valid_reg) ? `ST_CONFLICT : `ST_GOOD;
        dec_unit_set = ~|valid_reg;
      end
      `OP_RELEASE6, `OP_RELEASE10: begin
        dec_status = (|valid_reg) ? `ST_CONFLICT : `ST_GOOD;
        dec_unit_clr = ~|valid_reg;
      end
      default: begin
        dec_status = `ST_CHECK;
        dec_sense = `SK_ILLEGAL;
        dec_asc = `ASC_BAD_OPCODE;
      end
    endcase
  end

  // ****************************************************
  // Reservation state updates
  // ****************************************************
  // Key table; a replaced key keeps its slot and reservation
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      valid_reg <= '0;
      key_tab_reg <= '0;
      owner_reg <= '0;
      resv_reg <= '0;
      scope_reg <= '0;
      type_reg <= '0;
    end else if (exec_fire) begin
      if (dec_wr) begin
        valid_reg[dec_wr_idx] <= 1'b1;
        key_tab_reg[dec_wr_idx] <= skey_reg;
        owner_reg[dec_wr_idx] <= init_id;
      end
      if (dec_res_set || dec_res_clr) begin
        resv_reg[dec_res_idx] <= dec_res_set;
        scope_reg[dec_res_idx] <= scope;
        type_reg[dec_res_idx] <= rtype;
      end
      if (dec_kill) begin
        valid_reg[sk_find[IDX_W-1:0]] <= 1'b0;
        resv_reg[sk_find[IDX_W-1:0]] <= 1'b0;
      end
    end
  end

  // Generation counter; reset stands for power-on and hard reset
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      gen_reg <= `GEN_RESET;
    end else if (exec_fire && dec_gen_inc) begin
      gen_reg <= gen_reg + 32'h00000001;
    end
  end

  // Completion status of the last command
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      status_reg <= `ST_GOOD;
      sense_reg <= `SK_NONE;
      asc_reg <= 8'h00;
      ascq_reg <= 8'h00;
    end else if (exec_fire) begin
      status_reg <= dec_status;
      sense_reg <= dec_sense;
      asc_reg <= dec_asc;
      ascq_reg <= dec_ascq;
    end
  end

  // Conventional unit reservation flag
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      unit_res_reg <= 1'b0;
    end else if (exec_fire && (dec_unit_set || dec_unit_clr)) begin
      unit_res_reg <= dec_unit_set;
    end
  end

  // Unit attention per initiator; a new preempt beats a same-cycle clear
  logic [NUM_INIT-1:0] ua_set; // Preempted owner this cycle
  assign ua_set = (exec_fire && dec_kill) ? (NUM_INIT'(1) << owner_reg[sk_find[IDX_W-1:0]]) : '0;
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ua_pending_out <= '0;
    end else if (wb_fire && wb_we_in && adr == `REG_UA) begin
      ua_pending_out <= (ua_pending_out & ~wb_dat_in[NUM_INIT-1:0]) | ua_set;
    end else begin
      ua_pending_out <= ua_pending_out | ua_set;
    end
  end

  // Abort pulse telling the queue to flush the preempted owner
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      abort_valid_out <= 1'b0;
      abort_initiator_out <= '0;
    end else begin
      abort_valid_out <= exec_fire && dec_kill;
      if (exec_fire && dec_kill) begin
        abort_initiator_out <= owner_reg[sk_find[IDX_W-1:0]];
      end
    end
  end

  // ****************************************************
  // Read reservations data stream
  // ****************************************************
  logic [7:0] desc_ptr; // Offset past the header
  logic [7:0] rr_byte; // Byte at the read pointer
  // Descriptors are packed in slot order, one per held reservation
  always_comb begin
    int rank;
    rank = 0;
    desc_ptr = rd_ptr_reg - `RR_HDR_BYTES;
    rr_byte = 8'h00;
    if (rd_ptr_reg < 8'h04) begin
      rr_byte = byte_of32(gen_reg, rd_ptr_reg[1:0]);
    end else if (rd_ptr_reg < `RR_HDR_BYTES) begin
      rr_byte = byte_of32({25'h0000000, nres, 4'h0}, rd_ptr_reg[1:0]);
    end else begin
      for (int i = 0; i < NUM_KEYS; i++) begin
        if (resv_reg[i]) begin
          if (rank == int'(desc_ptr[7:4])) begin
            if (desc_ptr[3:0] < `DESC_KEY_BYTES) begin
              rr_byte = key_tab_reg[i][8*(7-int'(desc_ptr[2:0])) +: 8];
            end else if (desc_ptr[3:0] == `DESC_SCOPE_TYPE) begin
              rr_byte = {scope_reg[i], type_reg[i]};
            end
            // Address, reserved and extent bytes stay zero
          end
          rank = rank + 1;
        end
      end
    end
  end

  // Read pointer: set by software, advances on each data read
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rd_ptr_reg <= 8'h00;
    end else if (exec_fire && dec_ptr_rst) begin
      rd_ptr_reg <= 8'h00;
    end else if (wb_fire && wb_we_in && adr == `REG_RDPTR && wb_sel_in[0]) begin
      rd_ptr_reg <= wb_dat_in[7:0];
    end else if (wb_fire && !wb_we_in && adr == `REG_RDATA) begin
      rd_ptr_reg <= rd_ptr_reg + 8'h01;
    end
  end

  // Read data captured the cycle before acknowledge; unmapped reads zero
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      wb_dat_out <= 32'h00000000;
    end else if (wb_cyc_in && wb_stb_in && !ack_reg) begin
      case (adr)
        `REG_CMD: wb_dat_out <= cmd_reg;
        `REG_PLEN: wb_dat_out <= {16'h0000, plen_reg};
        `REG_RKEY_LO: wb_dat_out <= rkey_reg[31:0];
        `REG_RKEY_HI: wb_dat_out <= rkey_reg[63:32];
        `REG_SKEY_LO: wb_dat_out <= skey_reg[31:0];
        `REG_SKEY_HI: wb_dat_out <= skey_reg[63:32];
        `REG_STATUS: wb_dat_out <= {ascq_reg, asc_reg, 4'h0, sense_reg, status_reg};
        `REG_GEN: wb_dat_out <= gen_reg;
        `REG_UA: wb_dat_out <= 32'(ua_pending_out);
        `REG_RDPTR: wb_dat_out <= {24'h000000, rd_ptr_reg};
        `REG_RDATA: wb_dat_out <= {24'h000000, rr_byte};
        `REG_UNIT: wb_dat_out <= {28'h0000000, 1'b0, nres == 3'h0 ? 1'b0 : 1'b1, |valid_reg, unit_res_reg};
        default: wb_dat_out <= 32'h00000000;
      endcase
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  logic pr_go; // Persistent command taking effect
  assign pr_go = exec_fire && opcode == `OP_PR_OUT;
  a_gen_steps: assert property (exec_fire && dec_gen_inc |=> gen_reg == $past(gen_reg) + 32'h00000001)
    else $error("generation did not step");
  a_gen_clear: assert property (disable iff (1'b0) !reset_n_in |=> gen_reg == `GEN_RESET)
    else $error("generation not cleared");
  a_unit_block: assert property (pr_go && unit_res_reg |=> status_reg == `ST_CONFLICT)
    else $error("unit reservation ignored");
  a_plen_check: assert property (pr_go && !unit_res_reg && plen_reg != `PLIST_LEN |=> asc_reg == `ASC_PLIST_LEN)
    else $error("bad length accepted");
  a_conv_block: assert property (exec_fire && |valid_reg && !unit_res_reg |=> !unit_res_reg)
    else $error("unit reservation over keys");
  a_preempt_ua: assert property (exec_fire && dec_kill |=> ua_pending_out[abort_initiator_out])
    else $error("no attention after preempt");
  // Main scenarios reached
  c_preempt: cover property (exec_fire && dec_kill);
  c_reserve: cover property (exec_fire && dec_res_set);
  c_table_full: cover property (pr_go && is_reg && !free_hit);
endmodule : persistent_reservation_manager

// File: design/persistent_reservation_defs.svh
`ifndef PERSISTENT_RESERVATION_DEFS_SVH
`define PERSISTENT_RESERVATION_DEFS_SVH
// Functional notes
// - Generation counts successful register and preempt
// - Reset clears generation counter to zero
// - Read data: generation, length n-7, descriptors
// - Descriptor: key, address, scope/type byte 13
// - Descriptor address and extent read as zero
// - Unit reservation active rejects reservation-out
// - Parameter list length must be 18h
// - Only supported service actions; others illegal
// - Unknown key on register stores new key
// - Registered key: foreign conflicts, own replaced
// - Fifth key registration gets reservation conflict
// - Keys registered: conventional reserve/release conflict
// - Unregistered requester gets reservation conflict
// - Key owned by another initiator conflicts
// - Conflicting reserve rejected; reservation then governs
// - Release of unknown key returns good
// - Release scope/type mismatch: invalid release check
// - Unregistered preempt key: reserve without preempting
// - Registered preempt key: reserve, drop key, abort
// - Cleared key raises preempted unit attention
// - Only whole unit scope; register ignores scope
// - Only types 1h, 3h, 5h, 6h accepted
// ****************************************************
// Register byte offsets
// ****************************************************
`define REG_CMD 8'h00
`define REG_PLEN 8'h04
`define REG_RKEY_LO 8'h08
`define REG_RKEY_HI 8'h0C
`define REG_SKEY_LO 8'h10
`define REG_SKEY_HI 8'h14
`define REG_GO 8'h18
`define REG_STATUS 8'h1C
`define REG_GEN 8'h20
`define REG_UA 8'h24
`define REG_RDPTR 8'h28
`define REG_RDATA 8'h2C
`define REG_UNIT 8'h30
// ****************************************************
// Command register field positions
// ****************************************************
`define CMD_OPC_LSB 0
`define CMD_SA_LSB 8
`define CMD_TYPE_LSB 16
`define CMD_SCOPE_LSB 20
`define CMD_INIT_LSB 24
// ****************************************************
// Opcodes, lengths and answer codes
// ****************************************************
`define OP_PR_IN 8'h5E
`define OP_PR_OUT 8'h5F
`define OP_RESERVE6 8'h16
`define OP_RELEASE6 8'h17
`define OP_RESERVE10 8'h56
`define OP_RELEASE10 8'h57
`define PLIST_LEN 16'h0018
`define SA_IN_READ_RES 5'h01
`define SCOPE_WHOLE_UNIT 4'h0
`define ST_GOOD 8'h00
`define ST_CHECK 8'h02
`define ST_CONFLICT 8'h18
`define SK_NONE 4'h0
`define SK_ILLEGAL 4'h5
`define ASC_BAD_OPCODE 8'h20
`define ASC_PLIST_LEN 8'h1A
`define ASC_BAD_CDB 8'h24
`define ASC_BAD_RELEASE 8'h26
`define ASCQ_BAD_RELEASE 8'h04
`define GEN_RESET 32'h00000000
`define RR_HDR_BYTES 8'h08
`define DESC_KEY_BYTES 4'h8
`define DESC_SCOPE_TYPE 4'hD
`endif

// File: design/persistent_reservation_pkg.sv
package persistent_reservation_pkg;
  // Reservation key as carried in parameter lists
  typedef logic [63:0] key_t;
  // Reservation-out service actions
  typedef enum logic [4:0] {
    SA_REGISTER = 5'h00,
    SA_RESERVE = 5'h01,
    SA_RELEASE = 5'h02,
    SA_CLEAR = 5'h03,
    SA_PREEMPT = 5'h04,
    SA_PREEMPT_ABORT = 5'h05,
    SA_REGISTER_IGNORE = 5'h06
  } svc_act_t;
  // Supported reservation types
  typedef enum logic [3:0] {
    TY_WRITE_EXCL = 4'h1,
    TY_EXCL_ACCESS = 4'h3,
    TY_WRITE_EXCL_REG = 4'h5,
    TY_EXCL_ACCESS_REG = 4'h6
  } res_type_t;
endpackage : persistent_reservation_pkg

// File: test/initiator_model.sv
`timescale 1ns/1ps
`include "persistent_reservation_defs.svh"
// ****************
// Initiator model
// ****************
module initiator_model
  import persistent_reservation_pkg::*;
(
  input wire logic clk_in,
  input wire logic ack_in,
  output logic cyc_out,
  output logic we_out,
  output logic [7:0] adr_out,
  output logic [31:0] dat_out,
  output logic bad_out
);
  initial {cyc_out, we_out, adr_out, dat_out, bad_out} = '0;
  // One classic cycle; bounded wait so a dead slave cannot hang the run
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    cyc_out <= 1'b1;
    we_out <= w;
    adr_out <= a;
    dat_out <= d;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack_in !== 1'b1 && n < 50);
    bad_out <= (n >= 50);
    cyc_out <= 1'b0;
  endtask : xfer
  // Command block, length, both keys whole, then execute
  task automatic cmd(input logic [2:0] i, input logic [7:0] op, input logic [4:0] sa, input logic [3:0] ty,
    input logic [3:0] sc, input logic [15:0] pl, input key_t rk, input key_t sk);
    xfer(1'b1, `REG_CMD, {5'h0, i, sc, ty, 3'h0, sa, op});
    xfer(1'b1, `REG_PLEN, {16'h0, pl});
    xfer(1'b1, `REG_RKEY_LO, rk[31:0]);
    xfer(1'b1, `REG_RKEY_HI, rk[63:32]);
    xfer(1'b1, `REG_SKEY_LO, sk[31:0]);
    xfer(1'b1, `REG_SKEY_HI, sk[63:32]);
    xfer(1'b1, `REG_GO, 32'h1);
  endtask : cmd
endmodule : initiator_model

// File: test/tb_persistent_reservation_manager.sv
`timescale 1ns/1ps
`include "persistent_reservation_defs.svh"
module tb_persistent_reservation_manager
  import persistent_reservation_pkg::*;
;
  logic clk_in = 1'b0, reset_n_in = 1'b0, cyc, we, ack, abv, bad;
  logic [7:0] adr, ua;
  logic [31:0] dw, dr, gen;
  logic [2:0] abi;
  logic [191:0] rr;
  logic [31:0] exp_q[$];
  int fail_count, comparisons, aborts;
  key_t k[8];
  initial forever #5 clk_in = ~clk_in;
  persistent_reservation_manager dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(cyc),
    .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(dw), .wb_dat_out(dr),
    .wb_ack_out(ack), .abort_valid_out(abv), .abort_initiator_out(abi), .ua_pending_out(ua));
  initiator_model ini_u (.clk_in(clk_in), .ack_in(ack), .cyc_out(cyc), .we_out(we), .adr_out(adr),
    .dat_out(dw), .bad_out(bad));
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic final_report;
    fail_count += exp_q.size(); // Unanswered reads
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  // Watcher: each read answer is matched against the oldest note
  always @(posedge clk_in) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) check("read", dr, exp_q.pop_front());
    if (abv === 1'b1) aborts++;
  end
  // A bus wait that ran out ends the run as a failure
  always @(posedge bad) begin
    fail_count++;
    final_report();
  end
  task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    ini_u.xfer(1'b0, a, 32'h0);
  endtask : rd_exp
  function automatic logic [31:0] chk(input logic [7:0] asc, input logic [7:0] q);
    return {q, asc, 4'h0, `SK_ILLEGAL, `ST_CHECK};
  endfunction : chk
  task automatic po(input logic [2:0] i, input logic [4:0] sa, input key_t rk, input key_t sk,
    input logic [31:0] e, input logic [3:0] ty = 4'h1, input logic [3:0] sc = 4'h0, input logic [15:0] pl = 16'h0018);
    ini_u.cmd(i, `OP_PR_OUT, sa, ty, sc, pl, rk, sk);
    rd_exp(`REG_STATUS, e);
  endtask : po
  initial begin
    void'($urandom(32'hB41D));
    foreach (k[j]) k[j] = {$urandom, $urandom};
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd_exp(`REG_GEN, 32'h0);
    ini_u.cmd(3'h0, `OP_RESERVE6, 5'h0, 4'h0, 4'h0, 16'h0, 64'h0, 64'h0);
    rd_exp(`REG_STATUS, 32'h0);
    po(3'h0, SA_REGISTER, 64'h0, k[0], `ST_CONFLICT);
    ini_u.cmd(3'h0, `OP_RELEASE6, 5'h0, 4'h0, 4'h0, 16'h0, 64'h0, 64'h0);
    rd_exp(`REG_STATUS, 32'h0);
    $display("unit reservation test done");
    po(3'h0, SA_REGISTER, 64'h0, k[0], 32'h0);
    po(3'h1, SA_REGISTER, k[0], k[1], `ST_CONFLICT);
    po(3'h0, SA_REGISTER, k[0], k[4], 32'h0);
    for (int i = 1; i < 4; i++) po(i[2:0], SA_REGISTER, 64'h0, k[i], 32'h0);
    po(3'h4, SA_REGISTER, 64'h0, k[5], `ST_CONFLICT);
    rd_exp(`REG_GEN, 32'h5);
    $display("registration test done");
    po(3'h0, SA_RESERVE, k[4], 64'h0, chk(`ASC_PLIST_LEN, 8'h0), 4'h1, 4'h0, 16'h0010);
    for (int j = 0; j < 4; j++) po(3'h0, 5'(32'h1F070403 >> 8 * j), k[4], 64'h0, chk(`ASC_BAD_CDB, 8'h0));
    for (int s = 1; s < 3; s++) po(3'h0, SA_RESERVE, k[4], 64'h0, chk(`ASC_BAD_CDB, 8'h0), 4'h1, s[3:0]);
    for (int j = 0; j < 3; j++) po(3'h0, SA_RESERVE, k[4], 64'h0, chk(`ASC_BAD_CDB, 8'h0), 4'(12'h720 >> 4 * j));
    po(3'h5, SA_RESERVE, k[6], 64'h0, `ST_CONFLICT);
    po(3'h1, SA_RESERVE, k[4], 64'h0, `ST_CONFLICT);
    ini_u.cmd(3'h0, `OP_RESERVE10, 5'h0, 4'h0, 4'h0, 16'h0, 64'h0, 64'h0);
    rd_exp(`REG_STATUS, {24'h0, `ST_CONFLICT});
    $display("field checking test done");
    po(3'h0, SA_PREEMPT_ABORT, k[4], k[1], 32'h0);
    check("aborts", aborts, 32'h1);
    check("abort_initiator", {29'h0, abi}, 32'h1);
    check("ua_pending", {24'h0, ua}, 32'h2);
    po(3'h2, SA_RESERVE, k[2], 64'h0, `ST_CONFLICT);
    gen = 32'h6;
    ini_u.cmd(3'h0, `OP_PR_IN, `SA_IN_READ_RES, 4'h0, 4'h0, 16'h0018, 64'h0, 64'h0);
    ini_u.xfer(1'b1, `REG_RDPTR, 32'h0);
    rr = {gen, 32'h10, k[4], 64'h0000_0000_0001_0000};
    for (int b = 0; b < 24; b++) rd_exp(`REG_RDATA, {24'h0, rr[191-8*b -: 8]});
    po(3'h0, SA_RELEASE, k[4], 64'h0, chk(`ASC_BAD_RELEASE, `ASCQ_BAD_RELEASE), 4'h3);
    po(3'h0, SA_RELEASE, k[7], 64'h0, 32'h0);
    po(3'h0, SA_RELEASE, k[4], 64'h0, 32'h0);
    po(3'h2, SA_PREEMPT_ABORT, k[2], k[7], 32'h0, 4'h5);
    rd_exp(`REG_GEN, 32'h7);
    $display("preempt and release test done");
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd_exp(`REG_GEN, 32'h0);
    repeat (3) @(posedge clk_in);
    $display("reset test done");
    final_report();
  end
endmodule : tb_persistent_reservation_manager
